// *** rtl/ioc_pkg.sv ***
// package: register map, field layouts and host clock select codes for the io config bank
package ioc_pkg;

    // ==========================================================
    // register map
    // register indices as numbered for the bank; byte address is four times the index
    localparam logic [7:0] IOC_IDX_PAD_ANT = 8'h00;
    localparam logic [7:0] IOC_IDX_SUP_PAD = 8'h01;
    localparam int IOC_WORD_BYTES = 4;
    localparam logic [7:0] IOC_RST_PAD_ANT = 8'h00;
    localparam logic [7:0] IOC_RST_SUP_PAD = 8'h00;
    // bit 3 of the first register is reserved and always reads zero
    localparam logic [7:0] IOC_WMASK_PAD_ANT = 8'hf7;
    localparam logic [7:0] IOC_WMASK_SUP_PAD = 8'hff;
    localparam int IOC_REG_W = 8;
    localparam int IOC_BUS_W = 32;

    // ==========================================================
    // field layouts
    typedef struct packed {
        logic one_sided_drive;
        logic second_driver_sel;
        logic [1:0] i2c_hold_sel;
        logic reserved;
        logic host_clock_rate_hi;
        logic host_clock_rate_lo;
        logic slow_clock_suppress;
    } ioc_pad_ant_t;

    typedef struct packed {
        logic low_supply_sel;
        logic digital_reg_off;
        logic tune_dac_enable;
        logic sdo_pulldown_when_selected;
        logic sdo_pulldown_when_idle;
        logic pad_drive_boost;
        logic am_ref_sel;
        logic slow_ramp;
    } ioc_sup_pad_t;

    // ==========================================================
    // host clock pin source, decoded for the clock mux outside
    typedef enum logic [2:0] {
        IOC_HCK_LOW,
        IOC_HCK_DIV8,
        IOC_HCK_DIV4,
        IOC_HCK_DIV2,
        IOC_HCK_SLOW
    } ioc_hck_sel_t;

    localparam logic [1:0] IOC_RATE_DIV8 = 2'h0;
    localparam logic [1:0] IOC_RATE_DIV4 = 2'h1;
    localparam logic [1:0] IOC_RATE_DIV2 = 2'h2;
    localparam logic [1:0] IOC_RATE_OFF = 2'h3;

    // antenna path outputs travel together
    typedef struct packed {
        logic driver_out_a_en;
        logic driver_out_b_en;
        logic receive_in_b_sel;
    } ioc_ant_t;

endpackage

// *** rtl/ioc_host_clock.sv ***
// host clock pin source selection from rate code, crystal state and slow clock suppress
`timescale 1ns/1ns
`default_nettype none
module ioc_host_clock (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [1:0] rate,
    input wire logic slow_suppress,
    input wire logic xtal_running,
    output ioc_pkg::ioc_hck_sel_t sel_q
);
    import ioc_pkg::*;

    ioc_hck_sel_t sel_d;

    always_comb begin
        sel_d = IOC_HCK_LOW;
        if (rate == IOC_RATE_OFF) begin
            sel_d = IOC_HCK_LOW;
        end else if (xtal_running) begin
            case (rate)
                IOC_RATE_DIV8: sel_d = IOC_HCK_DIV8;
                IOC_RATE_DIV4: sel_d = IOC_HCK_DIV4;
                IOC_RATE_DIV2: sel_d = IOC_HCK_DIV2;
                default: sel_d = IOC_HCK_LOW;
            endcase
        end else if (!slow_suppress) begin
            sel_d = IOC_HCK_SLOW;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            sel_q <= IOC_HCK_LOW;
        end else begin
            sel_q <= sel_d;
        end
    end

    // ==========================================================
    // checks
    property p_rate_off;
        @(posedge clock) disable iff (!resetn)
        rate == IOC_RATE_OFF |=> sel_q == IOC_HCK_LOW;
    endproperty
    a_rate_off: assert property (p_rate_off) else $error("host clock not low with rate off");

    property p_fast_rate;
        @(posedge clock) disable iff (!resetn)
        xtal_running && rate == IOC_RATE_DIV2 |=> sel_q == IOC_HCK_DIV2;
    endproperty
    a_fast_rate: assert property (p_fast_rate) else $error("host clock not half crystal");

    property p_slow_clock;
        @(posedge clock) disable iff (!resetn)
        !xtal_running && rate != IOC_RATE_OFF
            |=> (sel_q == IOC_HCK_SLOW) == !$past(slow_suppress);
    endproperty
    a_slow_clock: assert property (p_slow_clock) else $error("slow clock selection wrong");
endmodule
`default_nettype wire

// *** rtl/ioc_pad_ctrl.sv ***
// serial data out pull-down and pad drive boost control
`timescale 1ns/1ns
`default_nettype none
module ioc_pad_ctrl (
    input wire logic clock,
    input wire logic resetn,
    input wire logic pd_selected,
    input wire logic pd_idle,
    input wire logic boost,
    input wire logic spi_mode,
    input wire logic chip_select_n,
    input wire logic sdo_driving,
    output logic sdo_pulldown_en_q,
    output logic pad_boost_q
);
    import ioc_pkg::*;

    logic pull_d;

    // pull only while nobody else owns the line; i2c mode never pulls
    always_comb begin
        pull_d = 1'b0;
        if (spi_mode) begin
            if (!chip_select_n) begin
                pull_d = pd_selected && !sdo_driving;
            end else begin
                pull_d = pd_idle;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            sdo_pulldown_en_q <= 1'b0;
        end else begin
            sdo_pulldown_en_q <= pull_d;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            pad_boost_q <= 1'b0;
        end else begin
            pad_boost_q <= boost;
        end
    end

    // ==========================================================
    // checks
    property p_i2c_no_pull;
        @(posedge clock) disable iff (!resetn)
        !spi_mode |=> !sdo_pulldown_en_q;
    endproperty
    a_i2c_no_pull: assert property (p_i2c_no_pull) else $error("pull-down active in i2c mode");

    property p_idle_pull;
        @(posedge clock) disable iff (!resetn)
        spi_mode && chip_select_n |=> sdo_pulldown_en_q == $past(pd_idle);
    endproperty
    a_idle_pull: assert property (p_idle_pull) else $error("idle pull-down wrong");

    property p_selected_pull;
        @(posedge clock) disable iff (!resetn)
        spi_mode && !chip_select_n && sdo_driving |=> !sdo_pulldown_en_q;
    endproperty
    a_selected_pull: assert property (p_selected_pull) else $error("pull-down fights driver");

    property p_boost;
        @(posedge clock) disable iff (!resetn)
        $rose(boost) |=> pad_boost_q ##1 pad_boost_q || !$past(boost);
    endproperty
    a_boost: assert property (p_boost) else $error("pad boost not applied");
endmodule
`default_nettype wire

// *** rtl/ioc_config_regs.sv ***
// io configuration register bank: avalon slave, antenna, tuning, host clock and pad control
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module ioc_config_regs #(
    parameter int ADDR_W = 4
) (
    input wire logic clock,
    input wire logic resetn,
    // avalon-mm slave, byte addresses
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [ioc_pkg::IOC_BUS_W-1:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [ioc_pkg::IOC_BUS_W-1:0] readdata,
    output logic waitrequest,
    // state from neighbouring units
    input wire logic ready_mode_en,
    input wire logic xtal_running,
    input wire logic spi_mode,
    input wire logic chip_select_n,
    input wire logic sdo_driving,
    // controls
    output ioc_pkg::ioc_ant_t antenna,
    output logic tune_dac_en,
    output logic tune_hold_fixed,
    output ioc_pkg::ioc_hck_sel_t host_clock_sel,
    output logic sdo_pulldown_en,
    output logic pad_boost
);
    import ioc_pkg::*;

    // ==========================================================
    // elaboration checks
    if (ADDR_W < 3 || ADDR_W > 8) begin : g_bad_addr_w
        $error("ADDR_W must be 3 to 8");
    end

    // ==========================================================
    // bus decode
    localparam int IDX_W = ADDR_W - 2;

    ioc_pad_ant_t pad_ant_q;
    ioc_sup_pad_t sup_pad_q;
    logic waitrequest_q;
    logic [IOC_BUS_W-1:0] readdata_q;
    logic req;
    logic accept;
    logic [IDX_W-1:0] idx;
    logic low_bits_zero;
    logic hit_pad_ant;
    logic hit_sup_pad;
    logic [IOC_BUS_W-1:0] read_mux;

    assign req = read || write;
    // transfer completes at the edge where waitrequest is seen low
    assign accept = req && !waitrequest_q;
    assign idx = address[ADDR_W-1:2];
    assign low_bits_zero = (address[1:0] == 2'h0);
    assign hit_pad_ant = low_bits_zero && (idx == IDX_W'(IOC_IDX_PAD_ANT));
    assign hit_sup_pad = low_bits_zero && (idx == IDX_W'(IOC_IDX_SUP_PAD));

    // unmapped or misaligned addresses read zero and drop writes
    always_comb begin
        read_mux = '0;
        if (hit_pad_ant) begin
            read_mux[IOC_REG_W-1:0] = pad_ant_q;
        end else if (hit_sup_pad) begin
            read_mux[IOC_REG_W-1:0] = sup_pad_q;
        end
    end

    // one wait cycle per access: low for exactly one cycle, then high again
    always_ff @(posedge clock) begin
        if (!resetn) begin
            waitrequest_q <= 1'b1;
        end else if (req && waitrequest_q) begin
            waitrequest_q <= 1'b0;
        end else begin
            waitrequest_q <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            readdata_q <= '0;
        end else if (read && waitrequest_q) begin
            readdata_q <= read_mux;
        end
    end

    assign readdata = readdata_q;
    assign waitrequest = waitrequest_q;

    // ==========================================================
    // register storage
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pad_ant_q <= IOC_RST_PAD_ANT;
        end else if (accept && write && hit_pad_ant && byteenable[0]) begin
            pad_ant_q <= writedata[IOC_REG_W-1:0] & IOC_WMASK_PAD_ANT;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            sup_pad_q <= IOC_RST_SUP_PAD;
        end else if (accept && write && hit_sup_pad && byteenable[0]) begin
            sup_pad_q <= writedata[IOC_REG_W-1:0] & IOC_WMASK_SUP_PAD;
        end
    end

    // ==========================================================
    // antenna driver and input selection
    always_ff @(posedge clock) begin
        if (!resetn) begin
            antenna <= '{driver_out_a_en: 1'b1, driver_out_b_en: 1'b1, receive_in_b_sel: 1'b0};
        end else if (!pad_ant_q.one_sided_drive) begin
            antenna.driver_out_a_en <= 1'b1;
            antenna.driver_out_b_en <= 1'b1;
            antenna.receive_in_b_sel <= 1'b0;
        end else begin
            antenna.driver_out_a_en <= !pad_ant_q.second_driver_sel;
            antenna.driver_out_b_en <= pad_ant_q.second_driver_sel;
            antenna.receive_in_b_sel <= pad_ant_q.second_driver_sel;
        end
    end

    // ==========================================================
    // antenna tuning converter gating
    // the fixed level is only defined once the regulators have come up;
    // remember that ready mode was seen so the hold is not claimed before
    logic ready_seen_q;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            ready_seen_q <= 1'b0;
        end else if (ready_mode_en) begin
            ready_seen_q <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            tune_dac_en <= 1'b0;
        end else begin
            tune_dac_en <= sup_pad_q.tune_dac_enable && ready_mode_en;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            tune_hold_fixed <= 1'b0;
        end else begin
            tune_hold_fixed <= sup_pad_q.tune_dac_enable && !ready_mode_en
                && (ready_seen_q || ready_mode_en);
        end
    end

    // ==========================================================
    // host clock and pad control
    ioc_host_clock u_host_clock (
        .clock(clock),
        .resetn(resetn),
        .rate({pad_ant_q.host_clock_rate_hi, pad_ant_q.host_clock_rate_lo}),
        .slow_suppress(pad_ant_q.slow_clock_suppress),
        .xtal_running(xtal_running),
        .sel_q(host_clock_sel)
    );

    ioc_pad_ctrl u_pad_ctrl (
        .clock(clock),
        .resetn(resetn),
        .pd_selected(sup_pad_q.sdo_pulldown_when_selected),
        .pd_idle(sup_pad_q.sdo_pulldown_when_idle),
        .boost(sup_pad_q.pad_drive_boost),
        .spi_mode(spi_mode),
        .chip_select_n(chip_select_n),
        .sdo_driving(sdo_driving),
        .sdo_pulldown_en_q(sdo_pulldown_en),
        .pad_boost_q(pad_boost)
    );

    // ==========================================================
    // checks
    sequence s_stalled_req;
        req && waitrequest_q;
    endsequence

    sequence s_granted;
        !waitrequest_q ##1 waitrequest_q;
    endsequence

    property p_bus_answer;
        @(posedge clock) disable iff (!resetn)
        s_stalled_req |=> s_granted;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one cycle");

    property p_write_lands;
        @(posedge clock) disable iff (!resetn)
        accept && write && hit_pad_ant && byteenable[0]
            |=> pad_ant_q == ($past(writedata[7:0]) & IOC_WMASK_PAD_ANT);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("write not stored");

    property p_readback;
        @(posedge clock) disable iff (!resetn)
        accept && read && hit_sup_pad
            |-> readdata_q == {{(IOC_BUS_W-IOC_REG_W){1'b0}}, sup_pad_q};
    endproperty
    a_readback: assert property (p_readback) else $error("read data mismatch");

    property p_reserved_zero;
        @(posedge clock) disable iff (!resetn)
        1'b1 |-> !pad_ant_q.reserved;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_differential;
        @(posedge clock) disable iff (!resetn)
        !pad_ant_q.one_sided_drive |=> antenna.driver_out_a_en && antenna.driver_out_b_en;
    endproperty
    a_differential: assert property (p_differential) else $error("differential drive lost");

    property p_one_sided;
        @(posedge clock) disable iff (!resetn)
        pad_ant_q.one_sided_drive |=> (antenna.driver_out_a_en != antenna.driver_out_b_en)
            && antenna.receive_in_b_sel == $past(pad_ant_q.second_driver_sel);
    endproperty
    a_one_sided: assert property (p_one_sided) else $error("one-sided pair wrong");

    property p_tune_gate;
        @(posedge clock) disable iff (!resetn)
        1'b1 |=> tune_dac_en == $past(sup_pad_q.tune_dac_enable && ready_mode_en);
    endproperty
    a_tune_gate: assert property (p_tune_gate) else $error("tuning converter gate wrong");

    property p_tune_hold;
        @(posedge clock) disable iff (!resetn)
        ready_seen_q && sup_pad_q.tune_dac_enable && !ready_mode_en
            |=> tune_hold_fixed && !tune_dac_en;
    endproperty
    a_tune_hold: assert property (p_tune_hold) else $error("tuning hold missing");

    property p_sup_write;
        @(posedge clock) disable iff (!resetn)
        accept && write && hit_sup_pad && byteenable[0]
            |=> sup_pad_q == ($past(writedata[7:0]) & IOC_WMASK_SUP_PAD);
    endproperty
    a_sup_write: assert property (p_sup_write) else $error("write not stored");

    property p_pad_read;
        @(posedge clock) disable iff (!resetn)
        accept && read && hit_pad_ant
            |-> readdata_q == {{(IOC_BUS_W-IOC_REG_W){1'b0}}, pad_ant_q};
    endproperty
    a_pad_read: assert property (p_pad_read) else $error("read data mismatch");

    // unmapped reads must not leak a neighbour's value
    property p_zero_read;
        @(posedge clock) disable iff (!resetn)
        accept && read && !hit_pad_ant && !hit_sup_pad |-> readdata_q == '0;
    endproperty
    a_zero_read: assert property (p_zero_read) else $error("unmapped read not zero");

    property p_masked_write;
        @(posedge clock) disable iff (!resetn)
        accept && write && !byteenable[0] |=> $stable(pad_ant_q) && $stable(sup_pad_q);
    endproperty
    a_masked_write: assert property (p_masked_write) else $error("write not masked");

    sequence s_idle;
        !req;
    endsequence

    property p_idle_wait;
        @(posedge clock) disable iff (!resetn)
        s_idle |=> waitrequest_q;
    endproperty
    a_idle_wait: assert property (p_idle_wait) else $error("idle wait lost");

    property p_early_hold;
        @(posedge clock) disable iff (!resetn)
        !ready_seen_q && !ready_mode_en |=> !tune_hold_fixed;
    endproperty
    a_early_hold: assert property (p_early_hold) else $error("hold before ready mode");

    // no disable here: this one watches the reset itself
    property p_reset_state;
        @(posedge clock)
        !resetn |=> waitrequest_q && pad_ant_q == IOC_RST_PAD_ANT
            && sup_pad_q == IOC_RST_SUP_PAD && !ready_seen_q;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
endmodule
`default_nettype wire

// *** verif/ioc_host_model.sv ***
// host side model: turns the host clock source select into the pin the host sees
`timescale 1ns/1ns
`default_nettype none
module ioc_host_model #(
    parameter int SLOW_HALF = 16
) (
    input wire logic clock,
    input wire logic resetn,
    input wire ioc_pkg::ioc_hck_sel_t sel,
    output logic mcu_pin
);
    import ioc_pkg::*;
    // ==========================================================
    // divider model
    // slow clock shortened to a small half period so a short window sees it
    int half;
    int cnt_q;
    always_comb begin
        case (sel)
            IOC_HCK_DIV8: half = 4;
            IOC_HCK_DIV4: half = 2;
            IOC_HCK_DIV2: half = 1;
            IOC_HCK_SLOW: half = SLOW_HALF;
            default: half = 0;
        endcase
    end
    always_ff @(posedge clock) begin
        if (!resetn || half == 0) begin
            cnt_q <= 0;
            mcu_pin <= 1'b0;
        end else if (cnt_q >= half - 1) begin
            cnt_q <= 0;
            mcu_pin <= ~mcu_pin;
        end else begin
            cnt_q <= cnt_q + 1;
        end
    end
endmodule
`default_nettype wire

// *** verif/tb_io_config_registers.sv ***
// self-checking bench for the io configuration register bank
`timescale 1ns/1ns
`default_nettype none
module tb_io_config_registers;
    import ioc_pkg::*;
    logic clock, resetn, read, write, waitrequest, ready_mode_en, xtal_running;
    logic spi_mode, chip_select_n, sdo_driving, tune_dac_en, tune_hold_fixed;
    logic sdo_pulldown_en, pad_boost, mcu_pin;
    logic [3:0] address, byteenable;
    logic [31:0] writedata, readdata, r;
    ioc_ant_t antenna;
    ioc_hck_sel_t host_clock_sel;
    int n_mismatch, compares, edges;

    ioc_config_regs #(.ADDR_W(4)) dut (.clock(clock), .resetn(resetn), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .ready_mode_en(ready_mode_en),
        .xtal_running(xtal_running), .spi_mode(spi_mode), .chip_select_n(chip_select_n),
        .sdo_driving(sdo_driving), .antenna(antenna), .tune_dac_en(tune_dac_en),
        .tune_hold_fixed(tune_hold_fixed), .host_clock_sel(host_clock_sel),
        .sdo_pulldown_en(sdo_pulldown_en), .pad_boost(pad_boost));
    ioc_host_model #(.SLOW_HALF(16)) host (.clock(clock), .resetn(resetn),
        .sel(host_clock_sel), .mcu_pin(mcu_pin));

    always #20 clock = ~clock;

    // ==========================================================
    // shared tasks
    task automatic close_out;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // waitrequest is judged and read data taken only at a rising edge; the caller releases after it
    task automatic wait_ack;
        int i;
        i = 0;
        @(posedge clock);
        while (waitrequest !== 1'b0 && i < 20) begin
            @(posedge clock);
            i++;
        end
        if (waitrequest !== 1'b0) begin
            check("waitrequest", waitrequest, 32'h0);
            close_out;
        end else begin
            r = readdata;
        end
    endtask
    task automatic bus_write(input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
        @(posedge clock);
        address <= a;
        writedata <= {24'h0, d};
        byteenable <= be;
        write <= 1'b1;
        wait_ack;
        write <= 1'b0;
    endtask
    task automatic bus_read(input logic [3:0] a);
        @(posedge clock);
        address <= a;
        read <= 1'b1;
        wait_ack;
        read <= 1'b0;
    endtask
    task automatic settle;
        repeat (3) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic pins(input logic sp, input logic cs, input logic sd, input logic rd,
                        input logic xt);
        @(posedge clock);
        spi_mode <= sp;
        chip_select_n <= cs;
        sdo_driving <= sd;
        ready_mode_en <= rd;
        xtal_running <= xt;
        settle;
    endtask
    task automatic count_edges;
        logic last;
        edges = 0;
        last = mcu_pin;
        repeat (64) begin
            @(negedge clock);
            if (mcu_pin === 1'b1 && last === 1'b0) edges++;
            last = mcu_pin;
        end
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset;
        settle;
        check("antenna", antenna, 3'b110);
        check("hck sel", host_clock_sel, IOC_HCK_SLOW);
        check("tune", {tune_dac_en, tune_hold_fixed}, 2'b00);
        check("boost", pad_boost, 1'b0);
        bus_read(4'h0);
        check("reg0 rst", r, 32'h0);
        bus_read(4'h4);
        check("reg1 rst", r, 32'h0);
    endtask
    task automatic t_regs;
        bus_write(4'h0, 8'hff, 4'h1);
        bus_read(4'h0);
        check("reg0", r, 32'hf7);
        bus_write(4'h4, 8'ha5, 4'h1);
        bus_write(4'h4, 8'h00, 4'h0);
        bus_read(4'h4);
        check("reg1", r, 32'ha5);
        bus_write(4'h8, 8'h5a, 4'h1);
        bus_read(4'h8);
        check("unmapped", r, 32'h0);
        bus_read(4'h4);
        check("reg1 kept", r, 32'ha5);
        bus_write(4'h4, 8'h00, 4'h1);
    endtask
    task automatic t_antenna;
        logic [7:0] d[3] = '{8'h80, 8'hc0, 8'h00};
        logic [2:0] e[3] = '{3'b100, 3'b011, 3'b110};
        for (int k = 0; k < 3; k++) begin
            bus_write(4'h0, d[k], 4'h1);
            settle;
            check("antenna", antenna, e[k]);
        end
    endtask
    task automatic t_clock;
        ioc_hck_sel_t s[4] = '{IOC_HCK_DIV8, IOC_HCK_DIV4, IOC_HCK_DIV2, IOC_HCK_LOW};
        int n[4] = '{8, 16, 32, 0};
        pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
        for (int k = 0; k < 4; k++) begin
            bus_write(4'h0, {5'h0, k[1:0], 1'b0}, 4'h1);
            settle;
            check("hck sel", host_clock_sel, s[k]);
            count_edges;
            check("hck edges", edges, n[k]);
        end
        pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        check("hck sel", host_clock_sel, IOC_HCK_LOW);
        bus_write(4'h0, 8'h00, 4'h1);
        settle;
        count_edges;
        check("slow edges", edges, 2);
        bus_write(4'h0, 8'h01, 4'h1);
        settle;
        check("hck sel", host_clock_sel, IOC_HCK_LOW);
    endtask
    task automatic t_tune;
        bus_write(4'h4, 8'h20, 4'h1);
        settle;
        check("tune", {tune_dac_en, tune_hold_fixed}, 2'b00);
        pins(1'b1, 1'b1, 1'b0, 1'b1, 1'b0); // ready set once first
        check("tune", {tune_dac_en, tune_hold_fixed}, 2'b10);
        pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        check("tune", {tune_dac_en, tune_hold_fixed}, 2'b01);
        bus_write(4'h4, 8'h00, 4'h1);
        settle;
        check("tune", {tune_dac_en, tune_hold_fixed}, 2'b00);
    endtask
    task automatic t_pads;
        bus_write(4'h4, 8'h14, 4'h1); // boost as the host would for its interface
        pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        check("pd", sdo_pulldown_en, 1'b1);
        check("boost", pad_boost, 1'b1);
        pins(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        check("pd", sdo_pulldown_en, 1'b0);
        pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        check("pd", sdo_pulldown_en, 1'b0);
        bus_write(4'h4, 8'h08, 4'h1);
        settle;
        check("pd", sdo_pulldown_en, 1'b1);
        check("boost", pad_boost, 1'b0);
        pins(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        check("pd", sdo_pulldown_en, 1'b0);
        bus_write(4'h4, 8'h10, 4'h1);
        pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        check("pd", sdo_pulldown_en, 1'b0);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        clock = 1'b0;
        resetn = 1'b0;
        address = '0;
        read = 1'b0;
        write = 1'b0;
        writedata = '0;
        byteenable = 4'h1;
        ready_mode_en = 1'b0;
        xtal_running = 1'b0;
        spi_mode = 1'b1;
        chip_select_n = 1'b1;
        sdo_driving = 1'b0;
        n_mismatch = 0;
        compares = 0;
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        t_reset;
        t_regs;
        t_antenna;
        t_clock;
        t_tune;
        t_pads;
        close_out;
    end
endmodule
`default_nettype wire
